// ==== logic/frt_pkg.sv ====
/*
 * Shared constants and types of the free-running 16-bit timer counter:
 * register word offsets, field positions, reset values and clock selects.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`default_nettype none

package frt_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------------
	localparam int          ADDR_W            = 5;
	localparam int          DATA_W            = 32;
	localparam logic [4:0]  OFF_CNT_HIGH      = 5'h00;
	localparam logic [4:0]  OFF_CNT_LOW       = 5'h04;
	localparam logic [4:0]  OFF_ALT_HIGH      = 5'h08;
	localparam logic [4:0]  OFF_ALT_LOW       = 5'h0c;
	localparam logic [4:0]  OFF_FLAG_REG      = 5'h10;
	localparam logic [4:0]  OFF_CTRL_ONE      = 5'h14;
	localparam logic [4:0]  OFF_CTRL_TWO      = 5'h18;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int          POS_OVF_FLAG      = 7;
	localparam int          POS_OVF_IRQ_EN    = 5;
	localparam int          POS_CLK_SEL_LO    = 2;
	localparam int          POS_CLK_SEL_HI    = 3;
	localparam int          POS_EXT_EDGE      = 0;
	localparam int          BYTE_LANE0        = 0;

	// ------------------------------------------------------------------
	// counter values
	// ------------------------------------------------------------------
	localparam logic [15:0] CNT_RELOAD        = 16'hfffc;
	localparam logic [15:0] CNT_TOP           = 16'hffff;
	localparam logic [15:0] CNT_WRAP          = 16'h0000;
	localparam logic [2:0]  PRESC_RESET       = 3'h0;
	localparam logic [2:0]  PRESC_STEP        = 3'h1;
	localparam logic [15:0] CNT_STEP          = 16'h0001;
	localparam logic [2:0]  PRESC_DIV2_MASK   = 3'h1;
	localparam logic [2:0]  PRESC_DIV4_MASK   = 3'h3;
	localparam logic [2:0]  PRESC_DIV8_MASK   = 3'h7;

	// ------------------------------------------------------------------
	// clock select codes
	// ------------------------------------------------------------------
	localparam logic [1:0]  CLK_SEL_DIV2      = 2'h0;
	localparam logic [1:0]  CLK_SEL_DIV4      = 2'h1;
	localparam logic [1:0]  CLK_SEL_DIV8      = 2'h2;
	localparam logic [1:0]  CLK_SEL_EXT       = 2'h3;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] timer_clock_select;
		logic       ext_edge_select;
	} ctrl_two_t;

	localparam ctrl_two_t CTRL_TWO_RESET = '{timer_clock_select: 2'h0, ext_edge_select: 1'b0};

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

endpackage : frt_pkg

`default_nettype wire

// ==== logic/pin_edge_sync.sv ====
/*
 * Two-flop synchroniser for a pin, followed by a selectable edge detector.
 * Assumes the pin is asynchronous to clk_in and much slower than it.
 */
`default_nettype none

module pin_edge_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// pin and edge choice
	input  wire logic pin_in,
	input  wire logic rising_sel_in,
	// one-cycle pulse per active edge
	output logic      edge_out
);

	logic sync_a;
	logic sync_b;
	logic sync_prev;

	// ------------------------------------------------------------------
	// synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_a    <= 1'b1;
			sync_b    <= 1'b1;
			sync_prev <= 1'b1;
		end else begin
			sync_a    <= pin_in;
			sync_b    <= sync_a;
			sync_prev <= sync_b;
		end
	end

	// ------------------------------------------------------------------
	// edge detector
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			edge_out <= 1'b0;
		end else if (rising_sel_in) begin
			edge_out <= sync_b & ~sync_prev;
		end else begin
			edge_out <= ~sync_b & sync_prev;
		end
	end

endmodule : pin_edge_sync

`default_nettype wire

// ==== logic/free_running_timer_counter.sv ====
/*
 * Counter core of a 16-bit general-purpose timer with an Avalon-MM slave.
 * Assumes a single 250 MHz clock, CPU halt and interrupt mask levels from
 * logic on the same clock, and an asynchronous external clock pin.
 */
// The address map and register access over Avalon-MM were left to the implementer.
`default_nettype none

module free_running_timer_counter #(
	parameter bit EXT_PIN_BONDED = 1'b1
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rst_b_in,
	// avalon-mm slave
	input  wire logic [frt_pkg::ADDR_W-1:0]   avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [3:0]                   avs_byteenable_in,
	input  wire logic [frt_pkg::DATA_W-1:0]   avs_writedata_in,
	output logic [frt_pkg::DATA_W-1:0]        avs_readdata_out,
	output logic                              avs_waitrequest_out,
	// cpu state
	input  wire logic                         cpu_halt_in,
	input  wire logic                         irq_mask_in,
	// external clock pin
	input  wire logic                         ext_clock_pin_in,
	// interrupt request and live count
	output logic                              timer_irq_out,
	output logic [15:0]                       count_out
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	frt_pkg::bus_state_t bus_state;
	frt_pkg::ctrl_two_t  ctrl_two;

	logic [15:0] count;
	logic [15:0] snap;
	logic [2:0]  presc;
	logic        tick;
	logic        ext_edge;
	logic        ext_level;
	logic        overflow_flag;
	logic        overflow_irq_enable;
	logic        clear_armed;
	logic [7:0]  low_buf;
	logic        low_buf_valid;

	logic        req;
	logic        take;
	logic        accept;
	logic        hit_main_high;
	logic        hit_main_low;
	logic        hit_alt_high;
	logic        hit_alt_low;
	logic        hit_flag_reg;
	logic        hit_ctrl_one;
	logic        hit_ctrl_two;
	logic        lane0_write;
	logic        reload;
	logic        wrap;
	logic        main_low_access;
	logic [7:0]  next_rdata;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	assign req           = avs_read_in | avs_write_in;
	assign take          = req & (bus_state == frt_pkg::BUS_IDLE);
	assign accept        = req & (bus_state == frt_pkg::BUS_ACK);
	assign hit_main_high = avs_address_in == frt_pkg::OFF_CNT_HIGH;
	assign hit_main_low  = avs_address_in == frt_pkg::OFF_CNT_LOW;
	assign hit_alt_high  = avs_address_in == frt_pkg::OFF_ALT_HIGH;
	assign hit_alt_low   = avs_address_in == frt_pkg::OFF_ALT_LOW;
	assign hit_flag_reg  = avs_address_in == frt_pkg::OFF_FLAG_REG;
	assign hit_ctrl_one  = avs_address_in == frt_pkg::OFF_CTRL_ONE;
	assign hit_ctrl_two  = avs_address_in == frt_pkg::OFF_CTRL_TWO;
	assign lane0_write   = avs_write_in & avs_byteenable_in[frt_pkg::BYTE_LANE0];

	// one wait state: data is sampled on the first edge, effects on the second
	assign avs_waitrequest_out = req & (bus_state == frt_pkg::BUS_IDLE);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_state <= frt_pkg::BUS_IDLE;
		end else begin
			unique case (bus_state)
				frt_pkg::BUS_IDLE: begin
					if (req) begin
						bus_state <= frt_pkg::BUS_ACK;
					end
				end
				frt_pkg::BUS_ACK: begin
					bus_state <= frt_pkg::BUS_IDLE;
				end
				default: begin
					bus_state <= frt_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (hit_main_high || hit_alt_high) begin
			next_rdata = count[15:8];
		end else if (hit_main_low || hit_alt_low) begin
			// buffered byte after a high read, live byte otherwise
			next_rdata = low_buf_valid ? low_buf : count[7:0];
		end else if (hit_flag_reg) begin
			next_rdata[frt_pkg::POS_OVF_FLAG] = overflow_flag;
		end else if (hit_ctrl_one) begin
			next_rdata[frt_pkg::POS_OVF_IRQ_EN] = overflow_irq_enable;
		end else if (hit_ctrl_two) begin
			next_rdata[frt_pkg::POS_CLK_SEL_HI:frt_pkg::POS_CLK_SEL_LO] =
				ctrl_two.timer_clock_select;
			next_rdata[frt_pkg::POS_EXT_EDGE] = ctrl_two.ext_edge_select;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			avs_readdata_out <= '0;
		end else if (take && avs_read_in) begin
			avs_readdata_out <= {24'h000000, next_rdata};
		end
	end

	// count seen by the request, so the captured low byte matches the high
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			snap <= frt_pkg::CNT_RELOAD;
		end else if (take) begin
			snap <= count;
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overflow_irq_enable <= 1'b0;
		end else if (accept && lane0_write && hit_ctrl_one) begin
			overflow_irq_enable <= avs_writedata_in[frt_pkg::POS_OVF_IRQ_EN];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_two <= frt_pkg::CTRL_TWO_RESET;
		end else if (accept && lane0_write && hit_ctrl_two) begin
			ctrl_two.timer_clock_select <=
				avs_writedata_in[frt_pkg::POS_CLK_SEL_HI:frt_pkg::POS_CLK_SEL_LO];
			ctrl_two.ext_edge_select <= avs_writedata_in[frt_pkg::POS_EXT_EDGE];
		end
	end

	// ------------------------------------------------------------------
	// external clock pin
	// ------------------------------------------------------------------
	assign ext_level = EXT_PIN_BONDED ? ext_clock_pin_in : 1'b1;

	// pin edges only count once resynchronised to the cpu clock
	pin_edge_sync u_ext_sync (
		.clk_in        (clk_in),
		.rst_b_in      (rst_b_in),
		.pin_in        (ext_level),
		.rising_sel_in (ctrl_two.ext_edge_select),
		.edge_out      (ext_edge)
	);

	// ------------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------------
	// runs from reset and holds only in halt, so two instances stay in step
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			presc <= frt_pkg::PRESC_RESET;
		end else if (!cpu_halt_in) begin
			presc <= presc + frt_pkg::PRESC_STEP;
		end
	end

	always_comb begin
		tick = 1'b0;
		unique case (ctrl_two.timer_clock_select)
			frt_pkg::CLK_SEL_DIV2: begin
				tick = (presc & frt_pkg::PRESC_DIV2_MASK) == frt_pkg::PRESC_DIV2_MASK;
			end
			frt_pkg::CLK_SEL_DIV4: begin
				tick = (presc & frt_pkg::PRESC_DIV4_MASK) == frt_pkg::PRESC_DIV4_MASK;
			end
			frt_pkg::CLK_SEL_DIV8: begin
				tick = presc == frt_pkg::PRESC_DIV8_MASK;
			end
			frt_pkg::CLK_SEL_EXT: begin
				tick = ext_edge;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	assign reload = accept && avs_write_in && (hit_main_low || hit_alt_low);
	// no wait-mode input: only halt stops the count
	assign wrap   = tick && !cpu_halt_in && !reload && count == frt_pkg::CNT_TOP;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= frt_pkg::CNT_RELOAD;
		end else if (reload) begin
			count <= frt_pkg::CNT_RELOAD;
		end else if (tick && !cpu_halt_in) begin
			count <= count + frt_pkg::CNT_STEP;
		end
	end

	assign count_out = count;

	// ------------------------------------------------------------------
	// low byte read buffer
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_buf       <= 8'h00;
			low_buf_valid <= 1'b0;
		end else if (accept && avs_read_in) begin
			if ((hit_main_high || hit_alt_high) && !low_buf_valid) begin
				low_buf       <= snap[7:0];
				low_buf_valid <= 1'b1;
			end else if (hit_main_low || hit_alt_low) begin
				low_buf_valid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// overflow flag
	// ------------------------------------------------------------------
	assign main_low_access = accept && hit_main_low;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			clear_armed <= 1'b0;
		end else if (accept && avs_read_in && hit_flag_reg && overflow_flag) begin
			clear_armed <= 1'b1;
		end else if (main_low_access) begin
			clear_armed <= 1'b0;
		end
	end

	// a wrap in the clearing cycle keeps the flag set
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overflow_flag <= 1'b0;
		end else if (wrap) begin
			overflow_flag <= 1'b1;
		end else if (main_low_access && clear_armed) begin
			overflow_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------------
	// stays pending in the flag until both enable and mask allow it
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			timer_irq_out <= 1'b0;
		end else begin
			timer_irq_out <= overflow_flag & overflow_irq_enable & ~irq_mask_in;
		end
	end

endmodule : free_running_timer_counter

`default_nettype wire

// ==== tb/ext_clock_source.sv ====
/* model of the external clock source on the timer pin
 * assumes it is timed by the bench cpu clock */
`default_nettype none
module ext_clock_source (
	// clock and level request
	input  wire logic clk_in,
	input  wire logic want_in,
	// external clock pin
	output logic      pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gap;
	initial begin
		pin_out = 1'b0;
		gap = 3'h0;
	end
	// pin follows request, edges kept at least five clocks apart
	always @(posedge clk_in) begin
		if (want_in != pin_out && gap >= 3'h4) begin
			pin_out <= want_in;
			gap <= 3'h0;
		end else if (gap != 3'h7) begin
			gap <= gap + 3'h1;
		end
	end
endmodule : ext_clock_source
`default_nettype wire

// ==== tb/frt_checker_sva.sv ====
/* port assertions of the timer counter
 * assumes a bind onto the top module */
`default_nettype none
module frt_checker (
	// watched ports
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic [4:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        cpu_halt_in,
	input wire logic        irq_mask_in,
	input wire logic        timer_irq_out,
	input wire logic [15:0] count_out
);
	logic [15:0] cnt_q;
	logic        low_wr;
	logic        high_rd;
	logic        req;
	always_ff @(posedge clk_in) cnt_q <= count_out;
	assign req = avs_read_in || avs_write_in;
	assign low_wr = avs_write_in && !avs_waitrequest_out
		&& (avs_address_in == frt_pkg::OFF_CNT_LOW || avs_address_in == frt_pkg::OFF_ALT_LOW);
	assign high_rd = avs_read_in && !avs_waitrequest_out
		&& (avs_address_in == frt_pkg::OFF_CNT_HIGH || avs_address_in == frt_pkg::OFF_ALT_HIGH);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	property p_wait_one; req && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
	property p_idle_free; !req |-> !avs_waitrequest_out; endproperty
	property p_start; $rose(rst_b_in) |-> count_out == frt_pkg::CNT_RELOAD; endproperty
	property p_halt; cpu_halt_in && !avs_write_in |=> $stable(count_out); endproperty
	property p_step;
		$changed(count_out) && !$past(avs_write_in) |-> count_out == cnt_q + 16'h0001;
	endproperty
	property p_reload; low_wr |=> count_out == frt_pkg::CNT_RELOAD; endproperty
	property p_high;
		high_rd |-> avs_readdata_out[31:8] == 24'h0
			&& (avs_readdata_out[7:0] == cnt_q[15:8] || avs_readdata_out[7:0] == count_out[15:8]);
	endproperty
	property p_mask; timer_irq_out |-> !$past(irq_mask_in); endproperty
	a_wait_one: assert property (p_wait_one) else $error("no single wait state");
	a_idle_free: assert property (p_idle_free) else $error("wait while idle");
	a_start: assert property (p_start) else $error("bad start count");
	a_halt: assert property (p_halt) else $error("count moved in halt");
	a_step: assert property (p_step) else $error("count skipped");
	a_reload: assert property (p_reload) else $error("no reload");
	a_high: assert property (p_high) else $error("high byte mismatch");
	a_mask: assert property (p_mask) else $error("irq while masked");
	c_wrap: cover property (count_out == 16'hffff ##1 count_out == 16'h0000);
	c_irq: cover property ($rose(timer_irq_out));
	c_halt_rd: cover property (cpu_halt_in && high_rd);
endmodule : frt_checker
`default_nettype wire

// ==== tb/tb.sv ====
/* self-checking bench of the timer counter
 * assumes the package, design and partner model compiled before it */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        halt = 1'b0;
	logic        mask = 1'b1;
	logic        want = 1'b0;
	logic [31:0] rdata;
	logic        wait_r;
	logic        pin;
	logic        irq;
	logic [15:0] cnt;
	logic [15:0] q;
	logic [15:0] c;
	int          n;
	int          fail_count = 0;
	int          n_compared = 0;
	always #2 clk_in = ~clk_in;
	free_running_timer_counter dut (.clk_in(clk_in), .rst_b_in(rst_b), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(4'h1),
		.avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
		.cpu_halt_in(halt), .irq_mask_in(mask), .ext_clock_pin_in(pin),
		.timer_irq_out(irq), .count_out(cnt));
	ext_clock_source src (.clk_in(clk_in), .want_in(want), .pin_out(pin));
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic give_verdict();
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
	endtask : cyc
	task automatic peek(input logic [15:0] exp, input logic of_irq);
		@(negedge clk_in);
		chk(of_irq ? {15'h0, irq} : cnt, exp);
		@(posedge clk_in);
	endtask : peek
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [15:0] r);
		int   k;
		logic b;
		k = 0;
		b = 1'b1;
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= {24'h0, d};
		while (b) begin
			@(negedge clk_in);
			b = wait_r;
			r = rdata[15:0];
			@(posedge clk_in);
			k++;
			if (k > 40) begin
				fail_count++;
				b = 1'b0;
			end
		end
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_in);
	endtask : bus
	task automatic meas(output int k);
		logic [15:0] s;
		@(negedge clk_in);
		s = cnt;
		k = 0;
		while (cnt === s && k < 100) begin
			@(negedge clk_in);
			k++;
		end
		s = cnt;
		k = 0;
		while (cnt === s && k < 100) begin
			@(negedge clk_in);
			k++;
		end
		@(posedge clk_in);
	endtask : meas
	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hb778));
		cyc(20);
		rst_b <= 1'b1;
		peek(16'hfffc, 1'b0);
		bus(0, frt_pkg::OFF_FLAG_REG, 8'h00, q);
		chk(q, 16'h0000);
		bus(1, frt_pkg::OFF_CTRL_ONE, 8'h20, q);
		bus(1, frt_pkg::OFF_CNT_LOW, 8'($urandom), q);
		cyc(16);
		bus(0, frt_pkg::OFF_CNT_LOW, 8'h00, q);
		bus(0, frt_pkg::OFF_FLAG_REG, 8'h00, q);
		chk(q, 16'h0080);
		bus(0, frt_pkg::OFF_ALT_LOW, 8'h00, q);
		bus(0, frt_pkg::OFF_FLAG_REG, 8'h00, q);
		chk(q, 16'h0080);
		peek(16'h0000, 1'b1);
		mask <= 1'b0;
		cyc(3);
		peek(16'h0001, 1'b1);
		bus(0, frt_pkg::OFF_CNT_LOW, 8'h00, q);
		bus(0, frt_pkg::OFF_FLAG_REG, 8'h00, q);
		chk(q, 16'h0000);
		peek(16'h0000, 1'b1);
		bus(1, frt_pkg::OFF_ALT_LOW, 8'($urandom), q);
		halt <= 1'b1;
		cyc(2);
		c = cnt;
		bus(0, frt_pkg::OFF_CNT_HIGH, 8'h00, q);
		chk(q, {8'h00, c[15:8]});
		halt <= 1'b0;
		cyc($urandom_range(12, 30));
		halt <= 1'b1;
		cyc(2);
		bus(0, frt_pkg::OFF_ALT_HIGH, 8'h00, q);
		chk(q, {8'h00, cnt[15:8]});
		bus(0, frt_pkg::OFF_CNT_LOW, 8'h00, q);
		chk(q, {8'h00, c[7:0]});
		bus(0, frt_pkg::OFF_ALT_LOW, 8'h00, q);
		chk(q, {8'h00, cnt[7:0]});
		c = cnt;
		cyc($urandom_range(3, 20));
		peek(c, 1'b0);
		halt <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			bus(1, frt_pkg::OFF_CTRL_TWO, {4'h0, 2'(s), 2'h0}, q);
			meas(n);
			chk(16'(n), 16'(2 << s));
		end
		for (int e = 1; e >= 0; e--) begin
			bus(1, frt_pkg::OFF_CTRL_TWO, {7'h06, e[0]}, q);
			bus(1, frt_pkg::OFF_CNT_LOW, 8'($urandom), q);
			want <= 1'b1;
			cyc(12);
			peek(e[0] ? 16'hfffd : 16'hfffc, 1'b0);
			want <= 1'b0;
			cyc(12);
			peek(16'hfffd, 1'b0);
		end
		bus(0, 5'h1c, 8'h00, q);
		chk(q, 16'h0000);
		rst_b <= 1'b0;
		cyc(3);
		rst_b <= 1'b1;
		peek(16'hfffc, 1'b0);
		bus(0, frt_pkg::OFF_FLAG_REG, 8'h00, q);
		chk(q, 16'h0000);
		give_verdict();
	end
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
endmodule : tb
bind free_running_timer_counter frt_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .cpu_halt_in(cpu_halt_in),
	.irq_mask_in(irq_mask_in), .timer_irq_out(timer_irq_out), .count_out(count_out));
`default_nettype wire
